/* diag_pkg.sv */
/*
 Shared constants and types for the amplifier fault-reporting link.
 Assumes a single 125 MHz clock shared by both ends.
*/
`default_nettype none
package diag_pkg;
    localparam int CLK_MHZ            = 125;
    localparam int OVL_RECHECK_US     = 1000;
    localparam int DIAG_CYCLE_US      = 100000;
    localparam int PWRUP_WAIT_US      = 500000;
    localparam int PWRDN_WAIT_US      = 20000;
    localparam int INSTALL_WAIT_US    = 200000;
    localparam int OFFSET_WAIT_US     = 30000;
    localparam int OVL_RECHECK_CYC    = OVL_RECHECK_US * CLK_MHZ;
    localparam int DIAG_CYCLE_CYC     = DIAG_CYCLE_US * CLK_MHZ;
    localparam int PWRUP_WAIT_CYC     = PWRUP_WAIT_US * CLK_MHZ;
    localparam int PWRDN_WAIT_CYC     = PWRDN_WAIT_US * CLK_MHZ;
    localparam int INSTALL_WAIT_CYC   = INSTALL_WAIT_US * CLK_MHZ;
    localparam int OFFSET_WAIT_CYC    = OFFSET_WAIT_US * CLK_MHZ;
    localparam int CNT_W              = 32;
    // Fault byte field positions
    localparam int FB_GND             = 0;
    localparam int FB_SUPPLY          = 1;
    localparam int FB_OPEN_OFS        = 2;
    localparam int FB_ACROSS          = 3;
    localparam logic [7:0] FB_RESET   = 8'h00;
    // Control byte field positions
    localparam int CB_STANDBY_OUT     = 0;
    localparam int CB_MUTE_OUT        = 1;
    localparam int CB_DIAG_EN         = 2;
    localparam int CB_OFFSET_EN       = 3;
    localparam logic [7:0] CB_RESET   = 8'h00;
    // Host command codes
    localparam logic [1:0] CMD_PWRUP   = 2'h0;
    localparam logic [1:0] CMD_PWRDN   = 2'h1;
    localparam logic [1:0] CMD_INSTALL = 2'h2;
    localparam logic [1:0] CMD_OFFSET  = 2'h3;
    // Host register offsets
    localparam logic [3:0] REG_CMD     = 4'h0;
    localparam logic [3:0] REG_STATUS  = 4'h1;
    localparam logic [3:0] REG_CH1     = 4'h2;
    localparam logic [3:0] REG_CH2     = 4'h3;
    localparam logic [3:0] REG_IRQ_ST  = 4'h4;
    localparam logic [3:0] REG_IRQ_CLR = 4'h5;
    localparam logic [3:0] REG_IRQ_EN  = 4'h6;
    localparam int IRQ_DONE           = 0;
    localparam int IRQ_FAULT          = 1;
    localparam int IRQ_W              = 2;
endpackage
`default_nettype wire

/* diag_if.sv */
/*
 Link between host controller and amplifier diagnostic engine.
 Assumes both ends on sys_clk; read/write are one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
interface diag_if;
    logic       wr_stb;
    logic [7:0] first_control_byte;
    logic       rd_stb;
    logic       rd_valid;
    logic [7:0] first_diag_status_byte;
    logic [7:0] second_diag_status_byte;
    modport amp  (input wr_stb, first_control_byte, rd_stb,
                  output rd_valid, first_diag_status_byte, second_diag_status_byte);
    modport host (output wr_stb, first_control_byte, rd_stb,
                  input rd_valid, first_diag_status_byte, second_diag_status_byte);
endinterface
`default_nettype wire

/* amp_diag.sv */
/*
 Amplifier diagnostic fault-reporting engine for two bridge channels.
 Assumes fault inputs are synchronous levels from the analog detectors.
*/
// Overview of operation
// R1: Source ground short plus supply short: both
// R2: Positive output is source, negative is sink
// R3: Permanent diagnostic never reports open load
// R4: Report only faults persisting whole period
// R5: Every status read re-arms all cycles; code drops reads made while a cycle runs (ST_DONE sets armed_r to rd_stb)
// R6: Read returns previous cycle result
// R7: Host powers up, waits 500 ms, unmutes
// R8: Host mutes, waits 20 ms, powers down
// R9: Host installs: enable, 200 ms, read repeatedly
// R10: Host offset test: enable, 30 ms, read
// R11: Offset window spans read or enable to read
// R12: Overload recheck 1 ms then 100 ms cycle
// R13: Latch channel faults at cycle end
`timescale 1ns/1ps
`default_nettype none
module amp_diag
    import diag_pkg::*;
#(
    parameter int RECHECK_CYC = OVL_RECHECK_CYC,
    parameter int CYCLE_CYC   = DIAG_CYCLE_CYC
)(
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    diag_if.amp             link,
    input  wire logic [1:0] gnd_pos,
    input  wire logic [1:0] gnd_neg,
    input  wire logic [1:0] short_to_supply,
    input  wire logic [1:0] short_across,
    input  wire logic [1:0] open_load,
    input  wire logic [1:0] offset_high,
    input  wire logic [1:0] overload,
    output logic            standby_out,
    output logic            mute_out
);
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_TURNON  = 3'b001,
        ST_WAIT    = 3'b010,
        ST_RECHECK = 3'b011,
        ST_PERM    = 3'b100,
        ST_DONE    = 3'b101
    } dstate_t;

    dstate_t          st_r;
    logic [CNT_W-1:0] cnt_r;
    logic [3:0]       persist_r [2];
    logic [1:0]       ofs_r;
    logic [7:0]       res_r     [2];
    logic [7:0]       ctrl_r;
    logic             armed_r;
    logic             turnon_r;
    logic [3:0]       now_f     [2];

    // Resolve coincident faults into reported set
    function automatic logic [3:0] resolve(input logic gp, input logic gn, input logic sv,
                                           input logic ac, input logic op, input logic perm);
        logic [3:0] f;
        f = 4'h0;
        if (sv)
        begin
            f[FB_SUPPLY] = 1'b1;
            f[FB_GND]    = gp; // R1
        end
        else if (gp || gn) // R2
            f[FB_GND] = 1'b1;
        else if (ac)
            f[FB_ACROSS] = 1'b1;
        else if (op && !perm) // R3
            f[FB_OPEN_OFS] = 1'b1;
        return f;
    endfunction

    always_comb
    begin
        for (int i = 0; i < 2; i++)
            now_f[i] = resolve(gnd_pos[i], gnd_neg[i], short_to_supply[i],
                               short_across[i], open_load[i], st_r != ST_TURNON);
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            ctrl_r <= CB_RESET;
        else if (link.wr_stb)
            ctrl_r <= link.first_control_byte;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            standby_out <= 1'b0;
            mute_out    <= 1'b0;
        end
        else
        begin
            standby_out <= ctrl_r[CB_STANDBY_OUT];
            mute_out    <= ctrl_r[CB_MUTE_OUT];
        end
    end

    // Offset persistence window
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            ofs_r <= 2'h0;
        else if (link.rd_stb || (link.wr_stb && link.first_control_byte[CB_OFFSET_EN]
                 && !ctrl_r[CB_OFFSET_EN]))
            ofs_r <= 2'h3; // R11
        else
            ofs_r <= ofs_r & offset_high; // R4
    end

    // Diagnostic cycle sequencer
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r         <= ST_IDLE;
            cnt_r        <= '0;
            armed_r      <= 1'b1;
            turnon_r     <= 1'b0;
            persist_r[0] <= 4'h0;
            persist_r[1] <= 4'h0;
            res_r[0]     <= FB_RESET;
            res_r[1]     <= FB_RESET;
        end
        else
        begin
            if (link.rd_stb)
                armed_r <= 1'b1; // R5
            // Read with no cycle running: next read sees the quiet window
            if (link.rd_stb && (st_r == ST_IDLE || st_r == ST_WAIT))
            begin
                for (int i = 0; i < 2; i++)
                begin
                    res_r[i] <= FB_RESET; // R6
                    res_r[i][FB_OPEN_OFS] <= ofs_r[i] & ctrl_r[CB_OFFSET_EN]; // R11
                end
            end
            case (st_r)
                ST_IDLE:
                begin
                    // Standby exit with diag enable: turn-on pulse first
                    if (link.wr_stb && link.first_control_byte[CB_STANDBY_OUT]
                        && link.first_control_byte[CB_DIAG_EN] && !ctrl_r[CB_STANDBY_OUT])
                        turnon_r <= 1'b1;
                    else if (ctrl_r[CB_DIAG_EN] && armed_r)
                    begin
                        st_r     <= (ctrl_r[CB_STANDBY_OUT] && !turnon_r) ? ST_WAIT
                                                                          : ST_TURNON;
                        persist_r[0] <= 4'hF;
                        persist_r[1] <= 4'hF;
                        cnt_r    <= '0;
                    end
                end
                ST_TURNON, ST_PERM:
                begin
                    persist_r[0] <= persist_r[0] & now_f[0]; // R4
                    persist_r[1] <= persist_r[1] & now_f[1];
                    if (cnt_r >= CNT_W'(CYCLE_CYC - 1))
                        st_r <= ST_DONE;
                    else
                        cnt_r <= cnt_r + 1'b1;
                end
                ST_WAIT:
                begin
                    turnon_r <= 1'b0;
                    cnt_r    <= '0;
                    if (!ctrl_r[CB_DIAG_EN])
                        st_r <= ST_IDLE;
                    else if (|overload)
                        st_r <= ST_RECHECK;
                end
                ST_RECHECK:
                begin
                    if (cnt_r >= CNT_W'(RECHECK_CYC - 1))
                    begin
                        cnt_r <= '0;
                        st_r  <= (|overload) ? ST_PERM : ST_WAIT; // R12
                    end
                    else
                        cnt_r <= cnt_r + 1'b1;
                end
                ST_DONE:
                begin
                    for (int i = 0; i < 2; i++)
                    begin
                        res_r[i] <= {4'h0, persist_r[i]}; // R13
                        res_r[i][FB_OPEN_OFS] <= persist_r[i][FB_OPEN_OFS] | ofs_r[i];
                    end
                    armed_r  <= link.rd_stb;
                    turnon_r <= 1'b0;
                    st_r     <= ST_IDLE;
                end
                default:
                    st_r <= ST_IDLE;
            endcase
        end
    end

    // Read returns stored previous-cycle results
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            link.rd_valid                <= 1'b0;
            link.first_diag_status_byte  <= FB_RESET;
            link.second_diag_status_byte <= FB_RESET;
        end
        else
        begin
            link.rd_valid <= link.rd_stb;
            if (link.rd_stb)
            begin
                link.first_diag_status_byte  <= res_r[0]; // R6
                link.second_diag_status_byte <= res_r[1];
            end
        end
    end
endmodule
`default_nettype wire

/* diag_host.sv */
/*
 Host controller running timed power, install and offset sequences.
 Assumes software on a plain register port; one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module diag_host
    import diag_pkg::*;
#(
    parameter int PWRUP_CYC   = PWRUP_WAIT_CYC,
    parameter int PWRDN_CYC   = PWRDN_WAIT_CYC,
    parameter int INSTALL_CYC = INSTALL_WAIT_CYC,
    parameter int OFFSET_CYC  = OFFSET_WAIT_CYC
)(
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    diag_if.host            link,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic [7:0]      rdata,
    output logic            irq
);
    typedef enum logic [2:0] {
        H_IDLE  = 3'b000,
        H_WAIT  = 3'b001,
        H_WRITE = 3'b010,
        H_READ  = 3'b011,
        H_CHECK = 3'b100
    } hstate_t;

    hstate_t          st_r;
    logic [CNT_W-1:0] cnt_r;
    logic [1:0]       cmd_r;
    logic [7:0]       ctrl_r;
    logic [7:0]       ch1_r;
    logic [7:0]       ch2_r;
    logic [IRQ_W-1:0] irq_st_r;
    logic [IRQ_W-1:0] irq_en_r;
    logic [IRQ_W-1:0] ev;
    logic             busy;
    logic             again;

    assign busy = (st_r != H_IDLE);
    // Fault still shown: read once more
    assign again = (cmd_r == CMD_OFFSET)
                 ? (link.first_diag_status_byte[FB_OPEN_OFS]
                    || link.second_diag_status_byte[FB_OPEN_OFS])
                 : (|link.first_diag_status_byte || |link.second_diag_status_byte);

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r   <= H_IDLE;
            cnt_r  <= '0;
            cmd_r  <= CMD_PWRUP;
            ctrl_r <= CB_RESET;
            ch1_r  <= FB_RESET;
            ch2_r  <= FB_RESET;
            link.wr_stb             <= 1'b0;
            link.rd_stb             <= 1'b0;
            link.first_control_byte <= CB_RESET;
        end
        else
        begin
            link.wr_stb <= 1'b0;
            link.rd_stb <= 1'b0;
            case (st_r)
                H_IDLE:
                begin
                    if (wr && addr == REG_CMD)
                    begin
                        cmd_r <= wdata[1:0];
                        cnt_r <= '0;
                        st_r  <= H_WAIT;
                        link.wr_stb <= 1'b1;
                        case (wdata[1:0])
                            CMD_PWRUP:   link.first_control_byte <= 8'h05; // R7
                            CMD_PWRDN:   link.first_control_byte <= ctrl_r & 8'hFD; // R8
                            CMD_INSTALL: link.first_control_byte <= ctrl_r | 8'h04; // R9
                            default:     link.first_control_byte <= ctrl_r | 8'h08; // R10
                        endcase
                    end
                end
                H_WAIT:
                begin
                    ctrl_r <= link.first_control_byte;
                    cnt_r  <= cnt_r + 1'b1;
                    if ((cmd_r == CMD_PWRUP   && cnt_r >= CNT_W'(PWRUP_CYC - 1))
                     || (cmd_r == CMD_PWRDN   && cnt_r >= CNT_W'(PWRDN_CYC - 1))
                     || (cmd_r == CMD_INSTALL && cnt_r >= CNT_W'(INSTALL_CYC - 1))
                     || (cmd_r == CMD_OFFSET  && cnt_r >= CNT_W'(OFFSET_CYC - 1)))
                        st_r <= (cmd_r == CMD_PWRUP || cmd_r == CMD_PWRDN) ? H_WRITE
                                                                           : H_READ;
                end
                H_WRITE:
                begin
                    link.wr_stb <= 1'b1;
                    link.first_control_byte <= (cmd_r == CMD_PWRUP)
                                               ? (ctrl_r | 8'h02) : 8'h00; // R7 R8
                    ctrl_r <= (cmd_r == CMD_PWRUP) ? (ctrl_r | 8'h02) : 8'h00;
                    st_r   <= H_IDLE;
                end
                H_READ:
                begin
                    link.rd_stb <= 1'b1;
                    st_r        <= H_CHECK;
                end
                H_CHECK:
                begin
                    if (link.rd_valid)
                    begin
                        ch1_r <= link.first_diag_status_byte;
                        ch2_r <= link.second_diag_status_byte;
                        st_r <= again ? H_READ : H_IDLE; // R9 R10
                    end
                end
                default:
                    st_r <= H_IDLE;
            endcase
        end
    end

    assign ev[IRQ_DONE]  = (st_r == H_WRITE) || (st_r == H_CHECK && link.rd_valid && !again);
    assign ev[IRQ_FAULT] = link.rd_valid && (|link.first_diag_status_byte
                                          || |link.second_diag_status_byte);

    // Sticky status, set wins over clear
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_st_r <= '0;
            irq_en_r <= '0;
        end
        else
        begin
            irq_st_r <= (irq_st_r & ~((wr && addr == REG_IRQ_CLR) ? wdata[IRQ_W-1:0] : '0))
                        | ev;
            if (wr && addr == REG_IRQ_EN)
                irq_en_r <= wdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata <= 8'h00;
            irq   <= 1'b0;
        end
        else
        begin
            irq <= |(irq_st_r & irq_en_r);
            case (addr)
                REG_STATUS: rdata <= {7'h00, busy};
                REG_CH1:    rdata <= ch1_r;
                REG_CH2:    rdata <= ch2_r;
                REG_IRQ_ST: rdata <= {6'h00, irq_st_r};
                REG_IRQ_EN: rdata <= {6'h00, irq_en_r};
                default:    rdata <= 8'h00;
            endcase
        end
    end
endmodule
`default_nettype wire

/* diag_link_properties.sv */
/*
 Concurrent checks on the host-to-amplifier diagnostic link.
 Assumes one clock, async active-low reset, shortened wait counts.
*/
`timescale 1ns/1ps
`default_nettype none
module diag_link_properties
    import diag_pkg::*;
#(
    parameter int PWRUP_CYC  = 40,
    parameter int PWRDN_CYC  = 30,
    parameter int OFFSET_CYC = 50
)(
    input wire logic       sys_clk,
    input wire logic       nrst,
    input wire logic       wr_stb,
    input wire logic [7:0] first_control_byte,
    input wire logic       rd_stb,
    input wire logic       rd_valid,
    input wire logic [7:0] first_diag_status_byte,
    input wire logic [7:0] second_diag_status_byte
);
    logic [7:0]  ctrl_r;
    logic [31:0] gap_r;
    logic        rd_seen_r;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    // Last written control byte
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            ctrl_r <= CB_RESET;
        else if (wr_stb)
            ctrl_r <= first_control_byte;
    end

    // Cycles since last write, read seen since
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            gap_r     <= 32'h0000_0000;
            rd_seen_r <= 1'b0;
        end
        else if (wr_stb)
        begin
            gap_r     <= 32'h0000_0000;
            rd_seen_r <= 1'b0;
        end
        else
        begin
            if (gap_r < 32'h0000_FFFF)
                gap_r <= gap_r + 32'h0000_0001;
            if (rd_stb)
                rd_seen_r <= 1'b1;
        end
    end

    a_read_answer: assert property (rd_stb |=> rd_valid)
        else $error("status read got no answer");
    a_answer_cause: assert property (rd_valid |-> $past(rd_stb))
        else $error("answer without a read");
    a_bytes_stand: assert property (!rd_valid |->
        $stable(first_diag_status_byte) && $stable(second_diag_status_byte))
        else $error("status bytes changed without a read");
    a_wake_with_diag: assert property (wr_stb && first_control_byte[CB_STANDBY_OUT]
        && !ctrl_r[CB_STANDBY_OUT] |-> first_control_byte[CB_DIAG_EN])
        else $error("standby exit without diagnostic enable");
    a_unmute_wait: assert property (wr_stb && first_control_byte[CB_MUTE_OUT]
        && !ctrl_r[CB_MUTE_OUT] |-> gap_r + 32'd2 >= PWRUP_CYC)
        else $error("unmute too early");
    a_mute_first: assert property (wr_stb && !first_control_byte[CB_STANDBY_OUT]
        && ctrl_r[CB_STANDBY_OUT] |-> !ctrl_r[CB_MUTE_OUT]
        && !first_control_byte[CB_DIAG_EN])
        else $error("standby entered while unmuted");
    a_sleep_wait: assert property (wr_stb && !first_control_byte[CB_STANDBY_OUT]
        && ctrl_r[CB_STANDBY_OUT] |-> gap_r + 32'd2 >= PWRDN_CYC)
        else $error("standby entered too soon after mute");
    a_offset_wait: assert property (rd_stb && !rd_seen_r && ctrl_r[CB_OFFSET_EN]
        |-> gap_r + 32'd2 >= OFFSET_CYC)
        else $error("offset read too early");
endmodule
`default_nettype wire

/* amp_fault_diag_reporting_tb_top.sv */
/*
 Testbench top: host controller and amplifier engine joined by the link.
 Assumes software register port, faults driven as synchronous levels.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        n_tests = n_tests + 1; \
        if ((got) !== (exp)) \
        begin \
            fail_count = fail_count + 1; \
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
        end \
    end
module amp_fault_diag_reporting_tb_top
    import diag_pkg::*;
;
    localparam int PUP = 40;
    localparam int PDN = 30;
    localparam int INS = 60;
    localparam int OFS = 50;
    logic       sys_clk = 1'b0;
    logic       nrst = 1'b0;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       irq;
    logic       standby_out;
    logic       mute_out;
    logic [1:0] gnd_pos;
    logic [1:0] gnd_neg;
    logic [1:0] sup;
    logic [1:0] across;
    logic [1:0] open_ld;
    logic [1:0] ofs;
    logic [1:0] ovl;
    int         fail_count = 0;
    int         n_tests = 0;

    always #4 sys_clk = ~sys_clk;

    diag_if i_diag_if ();
    amp_diag #(.RECHECK_CYC(10), .CYCLE_CYC(20)) i_amp_diag (.sys_clk(sys_clk),
        .nrst(nrst), .link(i_diag_if.amp), .gnd_pos(gnd_pos), .gnd_neg(gnd_neg),
        .short_to_supply(sup), .short_across(across), .open_load(open_ld),
        .offset_high(ofs), .overload(ovl), .standby_out(standby_out), .mute_out(mute_out));
    diag_host #(.PWRUP_CYC(PUP), .PWRDN_CYC(PDN), .INSTALL_CYC(INS), .OFFSET_CYC(OFS))
        i_diag_host (.sys_clk(sys_clk), .nrst(nrst), .link(i_diag_if.host), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
    diag_link_properties #(.PWRUP_CYC(PUP), .PWRDN_CYC(PDN), .OFFSET_CYC(OFS))
        i_diag_link_properties (.sys_clk(sys_clk), .nrst(nrst),
        .wr_stb(i_diag_if.wr_stb), .first_control_byte(i_diag_if.first_control_byte),
        .rd_stb(i_diag_if.rd_stb), .rd_valid(i_diag_if.rd_valid),
        .first_diag_status_byte(i_diag_if.first_diag_status_byte),
        .second_diag_status_byte(i_diag_if.second_diag_status_byte));

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr    <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd   <= 1'b0;
        @(negedge sys_clk);
        v = rdata;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] v;
        reg_rd(a, v);
        `CHK(v, e)
    endtask

    // Issue a command, poll busy until it drops
    task automatic run_cmd(input logic [1:0] c);
        logic [7:0] v;
        int         k;
        reg_wr(REG_CMD, {6'h00, c});
        repeat (2) @(posedge sys_clk);
        v = 8'h01;
        k = 0;
        while (v[0] !== 1'b0 && k < 500)
        begin
            reg_rd(REG_STATUS, v);
            k = k + 1;
        end
        repeat (2) @(posedge sys_clk);
        `CHK(v[0], 1'b0)
    endtask

    // Check the status bytes of the next link answer
    task automatic link_chk(input logic [7:0] e1, input logic [7:0] e2);
        @(posedge i_diag_if.rd_valid);
        @(negedge sys_clk);
        `CHK(i_diag_if.first_diag_status_byte, e1)
        `CHK(i_diag_if.second_diag_status_byte, e2)
    endtask

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        fail_count = fail_count + 1;
        final_report();
    end

    initial
    begin
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        {gnd_pos, gnd_neg, sup, across, open_ld, ofs, ovl} = 14'h0000;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        // Reset values, unmapped addresses read zero
        for (int i = 1; i < 16; i++)
            if (i != 5)
                rd_chk(4'(i), 8'h00);
        $display("Test reset done");
        reg_wr(REG_IRQ_EN, 8'h03);
        run_cmd(CMD_PWRUP);
        `CHK({standby_out, mute_out}, 2'b11)
        `CHK(irq, 1'b1)
        rd_chk(REG_IRQ_ST, 8'h01);
        reg_wr(REG_IRQ_EN, 8'h00);
        repeat (2) @(posedge sys_clk);
        `CHK(irq, 1'b0)
        reg_wr(REG_IRQ_CLR, 8'h03);
        reg_wr(REG_IRQ_EN, 8'h03);
        repeat (2) @(posedge sys_clk);
        `CHK(irq, 1'b0)
        rd_chk(REG_IRQ_ST, 8'h00);
        $display("Test power-up done");
        // Double faults: ch1 source ground + supply, ch2 sink ground + supply
        gnd_pos <= 2'b01;
        gnd_neg <= 2'b10;
        sup     <= 2'b11;
        ovl     <= 2'b11;
        run_cmd(CMD_INSTALL);
        rd_chk(REG_CH1, 8'h00);
        rd_chk(REG_CH2, 8'h00);
        repeat (40) @(posedge sys_clk);
        {gnd_pos, gnd_neg, sup, ovl} <= 8'h00;
        open_ld <= 2'b11;
        fork
            run_cmd(CMD_INSTALL);
            link_chk(8'h03, 8'h02);
        join
        rd_chk(REG_CH1, 8'h00);
        rd_chk(REG_CH2, 8'h00);
        rd_chk(REG_IRQ_ST, 8'h03);
        repeat (40) @(posedge sys_clk);
        run_cmd(CMD_INSTALL);
        rd_chk(REG_CH1, 8'h00);
        rd_chk(REG_CH2, 8'h00);
        $display("Test double faults done");
        // Ground short that drops out mid-period
        gnd_pos <= 2'b01;
        ovl     <= 2'b01;
        repeat (14) @(posedge sys_clk);
        gnd_pos <= 2'b00;
        repeat (40) @(posedge sys_clk);
        ovl <= 2'b00;
        run_cmd(CMD_INSTALL);
        rd_chk(REG_CH1, 8'h00);
        $display("Test persistence done");
        ofs <= 2'b10;
        run_cmd(CMD_OFFSET);
        fork
            run_cmd(CMD_OFFSET);
            begin
                link_chk(8'h00, 8'h04);
                @(posedge sys_clk);
                ofs <= 2'b00;
            end
        join
        rd_chk(REG_CH2, 8'h00);
        rd_chk(REG_CH1, 8'h00);
        ofs <= 2'b00;
        run_cmd(CMD_OFFSET);
        run_cmd(CMD_OFFSET);
        rd_chk(REG_CH2, 8'h00);
        $display("Test offset done");
        run_cmd(CMD_PWRDN);
        `CHK({standby_out, mute_out}, 2'b00)
        $display("Test power-down done");
        final_report();
    end
endmodule
`default_nettype wire
